// ===== dv/front_panel_model.sv
// partner model: front-panel push buttons, sounder jumper and the operator's alarm point
`timescale 1ns/1ps
module front_panel_model #(
  parameter int TICK_CYCLES = 10
) (
  // clock
  input wire logic clk_i,
  // buttons, jumper and alarm point toward the block
  output logic mode_button_o,
  output logic up_button_o,
  output logic down_button_o,
  output logic alarm_sounder_jumper_o,
  output logic [5:0] swr_limit_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle panel: buttons released, jumper open, alarm point at 2.0
  initial begin
    mode_button_o = 1'b0;
    up_button_o = 1'b0;
    down_button_o = 1'b0;
    alarm_sounder_jumper_o = 1'b0;
    swr_limit_o = 6'h14;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one press of 0 mode, 1 up, 2 down; pins change just after an edge
  task automatic press(input int which, input int ticks);
    @(posedge clk_i);
    #1;
    case (which)
      0: mode_button_o = 1'b1;
      1: up_button_o = 1'b1;
      default: down_button_o = 1'b1;
    endcase
    repeat (ticks * TICK_CYCLES) @(posedge clk_i);
    #1;
    mode_button_o = 1'b0;
    up_button_o = 1'b0;
    down_button_o = 1'b0;
    // gap so the release is seen before any next press
    repeat (4 * TICK_CYCLES) @(posedge clk_i);
  endtask : press
  // fit or remove the sounder jumper
  task automatic set_jumper(input logic fit);
    @(posedge clk_i);
    #1;
    alarm_sounder_jumper_o = fit;
  endtask : set_jumper
endmodule : front_panel_model

// ===== dv/meter_setup_menu_control_tb.sv
// testbench for the meter front-panel control block
`timescale 1ns/1ps
module meter_setup_menu_control_tb;
  import meter_pkg::*;
  localparam int TC = 10;
  typedef struct {int kind; logic [15:0] val;} note_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mode_b, up_b, down_b, jumper;
  logic [15:0] fwd = 16'h0000;
  logic [15:0] refp = 16'h0000;
  logic [5:0] swr = 6'h00;
  logic [5:0] lim;
  logic sample_o, peak_char_o, temp_celsius_o, cpu_reset_o, net_power_o, alarm_o, snooze_o, sounder_o;
  pwr_mode_t pwr_mode_o;
  screen_t screen_o;
  range_t range_sel_o;
  logic [15:0] disp_pwr_o, alarm_power_threshold_o;
  logic [5:0] disp_swr_o, user_setpoint_o;
  logic [11:0] low_max_o, mid_max_o, high_max_o;
  logic [8:0] hold_ticks_o;
  note_t notes[$];
  note_t cur;
  event chk_ev;
  int n_errors = 0;
  int n_compared = 0;
  int n_resets = 0;
  int gap = 0;
  int last_gap = 0;
  localparam int DK[9] = '{0, 1, 3, 4, 5, 11, 12, 13, 14};
  localparam logic [15:0] DV[9] = '{16'h0000, 16'h0000, 16'h0014, 16'h0000, 16'h0001, 16'h000f, 16'h0064, 16'h05dc,
    16'h00c8};
  ////////////////////////////////////////////////////////////////////////////////
  // clock, design and partner
  always #20 clk_i = ~clk_i;
  meter_setup_menu_control #(.TICK_CYCLES(TC)) u_meter_setup_menu_control (.clk_i(clk_i), .resetn_i(resetn_i),
    .mode_button_i(mode_b), .up_button_i(up_b), .down_button_i(down_b), .alarm_sounder_jumper_i(jumper),
    .fwd_pwr_i(fwd), .ref_pwr_i(refp), .swr_i(swr), .swr_limit_i(lim), .sample_o(sample_o),
    .pwr_mode_o(pwr_mode_o), .peak_char_o(peak_char_o), .disp_pwr_o(disp_pwr_o), .disp_swr_o(disp_swr_o),
    .screen_o(screen_o), .temp_celsius_o(temp_celsius_o), .cpu_reset_o(cpu_reset_o),
    .user_setpoint_o(user_setpoint_o), .alarm_power_threshold_o(alarm_power_threshold_o),
    .net_power_o(net_power_o), .range_sel_o(range_sel_o), .low_max_o(low_max_o), .mid_max_o(mid_max_o),
    .high_max_o(high_max_o), .hold_ticks_o(hold_ticks_o), .alarm_o(alarm_o), .snooze_o(snooze_o),
    .sounder_o(sounder_o));
  front_panel_model #(.TICK_CYCLES(TC)) u_front_panel_model (.clk_i(clk_i), .mode_button_o(mode_b),
    .up_button_o(up_b), .down_button_o(down_b), .alarm_sounder_jumper_o(jumper), .swr_limit_o(lim));
  ////////////////////////////////////////////////////////////////////////////////
  // pulse monitor: one-cycle outputs are counted at the falling edge, midway through the cycle they stand
  always @(negedge clk_i) begin
    if (cpu_reset_o === 1'b1) n_resets++;
    if (sample_o === 1'b1) begin
      last_gap = gap;
      gap = 1;
    end else begin
      gap++;
    end
  end
  function automatic logic [15:0] actual(input int k);
    case (k)
      0: return {13'h0000, screen_o};
      1: return {14'h0000, pwr_mode_o};
      2: return {15'h0000, peak_char_o};
      3: return {10'h000, user_setpoint_o};
      4: return alarm_power_threshold_o;
      5: return {15'h0000, net_power_o};
      6: return {14'h0000, range_sel_o};
      7: return {15'h0000, temp_celsius_o};
      8: return {15'h0000, alarm_o};
      9: return {15'h0000, snooze_o};
      10: return {15'h0000, sounder_o};
      11: return {4'h0, low_max_o};
      12: return {4'h0, mid_max_o};
      13: return {4'h0, high_max_o};
      14: return {7'h00, hold_ticks_o};
      15: return n_resets[15:0];
      16: return last_gap[15:0];
      17: return disp_pwr_o;
      default: return {10'h000, disp_swr_o};
    endcase
  endfunction : actual
  task automatic compare(input logic [15:0] exp, input logic [15:0] act, input int k);
    n_compared++;
    if (act !== exp) begin
      n_errors++;
      $display("wrong value at %0t: item %0d is %h, expected %h", $time, k, act, exp);
    end
  endtask : compare
  // watcher: on a new note it waits for the falling edge, where outputs are settled, then takes every queued note, oldest first
  always begin
    @(chk_ev);
    @(negedge clk_i);
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      compare(cur.val, actual(cur.kind), cur.kind);
    end
  end
  task automatic note_val(input int k, input logic [15:0] v);
    notes.push_back('{k, v});
    -> chk_ev;
  endtask : note_val
  task automatic tap(input int b);
    u_front_panel_model.press(b, 5);
  endtask : tap
  task automatic end_sim();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hff3ccb6d));
    repeat (2) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    repeat (3 * TC) @(posedge clk_i);
    for (int i = 0; i < 9; i++) note_val(DK[i], DV[i]);
    note_val(16, 16'h000a);
    for (int i = 1; i < 4; i++) begin
      tap(1);
      note_val(1, 16'(i % 3));
      note_val(2, {15'h0000, i == 1});
    end
    // alarm with random overload, jumper open then fitted
    #1;
    swr = 6'h14 + 6'($urandom_range(0, 40));
    fwd = 16'($urandom_range(600, 2000));
    refp = 16'($urandom_range(0, 500));
    repeat (5 * TC) @(posedge clk_i);
    note_val(8, 16'h0001);
    note_val(17, fwd - refp);
    note_val(18, {10'h000, swr});
    note_val(10, 16'h0000);
    u_front_panel_model.set_jumper(1'b1);
    repeat (5 * TC) @(posedge clk_i);
    note_val(10, 16'h0001);
    tap(2);
    note_val(9, 16'h0001);
    note_val(8, 16'h0000);
    repeat (1000 * TC) @(posedge clk_i);
    tap(2);
    repeat (5400 * TC) @(posedge clk_i);
    note_val(8, 16'h0000);
    for (int i = 0; i < 700 * TC && alarm_o !== 1'b1; i++) @(posedge clk_i);
    note_val(8, 16'h0001);
    // setup menu walk
    u_front_panel_model.press(0, 110);
    note_val(0, 16'h0001);
    tap(1);
    note_val(7, 16'h0001);
    tap(2);
    note_val(15, 16'h0001);
    tap(0);
    tap(1);
    note_val(3, 16'h0015);
    tap(2);
    tap(2);
    note_val(3, 16'h0013);
    tap(0);
    for (int i = 0; i < 4; i++) begin
      tap(2);
      note_val(4, (i == 0) ? 16'h0001 : (i == 1) ? 16'h000a : (i == 2) ? 16'h0064 : 16'h0000);
    end
    tap(1);
    note_val(5, 16'h0000);
    tap(0);
    for (int i = 1; i < 4; i++) begin
      tap(2);
      note_val(6, 16'(i % 3));
    end
    tap(1);
    note_val(11, 16'h0014);
    tap(0);
    tap(2);
    note_val(14, 16'h00af);
    // two seconds from setup pass calibration and land on main
    u_front_panel_model.press(0, 210);
    note_val(0, 16'h0000);
    u_front_panel_model.press(0, 210);
    note_val(0, 16'h0006);
    u_front_panel_model.press(0, 110);
    note_val(0, 16'h0000);
    // peak hold: a lower reading waits out the hold, a higher one restarts it
    tap(1);
    #1;
    fwd = 16'h1000;
    repeat (3 * TC) @(posedge clk_i);
    #1;
    fwd = 16'h0100;
    repeat (100 * TC) @(posedge clk_i);
    note_val(17, 16'h1000);
    #1;
    fwd = 16'h2000;
    repeat (3 * TC) @(posedge clk_i);
    #1;
    fwd = 16'h0100;
    repeat (150 * TC) @(posedge clk_i);
    note_val(17, 16'h2000);
    repeat (100 * TC) @(posedge clk_i);
    note_val(17, 16'h0100);
    // let the watcher take the last notes before the verdict
    repeat (2) @(negedge clk_i);
    end_sim();
  end
endmodule : meter_setup_menu_control_tb

// ===== rtl/button_timer.sv
// one button: synchroniser, press-length counter on the common tick, tap and hold events
`timescale 1ns/1ps
`include "meter_params.svh"
module button_timer
  import meter_pkg::*;
#(
  parameter int HOLD_TICKS = 100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // tick and raw button
  input wire logic tick_i,
  input wire logic btn_i,
  // events
  output logic tap_o,
  output logic hold_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [7:0] cnt;
    logic fired;
    logic tap;
    logic hold;
  } btn_state_t;
  btn_state_t st_q, st_d;

  // only the second stage is read; fired stops cnt at HOLD_TICKS so hold fires once per press
  always_comb begin
    st_d = st_q;
    st_d.s1 = btn_i;
    st_d.s2 = st_q.s1;
    st_d.prev = st_q.s2;
    st_d.tap = 1'b0;
    st_d.hold = 1'b0;
    if (st_q.s2 && tick_i && !st_q.fired) begin
      st_d.cnt = st_q.cnt + 8'h01;
      if (st_q.cnt + 8'h01 >= 8'(HOLD_TICKS)) begin
        st_d.hold = 1'b1; // R18
        st_d.fired = 1'b1;
      end
    end
    if (!st_q.s2 && st_q.prev) begin
      st_d.tap = !st_q.fired && (st_q.cnt < 8'(`TAP_MAX_TICKS));
      st_d.cnt = 8'h00;
      st_d.fired = 1'b0;
    end
  end

  // state register, cleared on reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_q <= '0; // R18
    end else begin
      st_q <= st_d;
    end
  end

  assign tap_o = st_q.tap;
  assign hold_o = st_q.hold;

  chk_tap_hold_excl: assert property (@(posedge clk_i) disable iff (!resetn_i) !(tap_o && hold_o)) // R18
    else $error("tap and hold at once");
endmodule : button_timer

// ===== rtl/meter_params.svh
// constants for the meter front-panel control block
`ifndef METER_PARAMS_SVH
`define METER_PARAMS_SVH
`define CLK_HZ 25000000
`define TICK_MS 10
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define SNOOZE_MS 60000
`define SNOOZE_TICKS (`SNOOZE_MS / `TICK_MS)
`define SETUP_HOLD_MS 1000
`define SETUP_HOLD_TICKS (`SETUP_HOLD_MS / `TICK_MS)
`define EXIT_HOLD_MS 2000
`define EXIT_HOLD_TICKS (`EXIT_HOLD_MS / `TICK_MS)
`define TAP_MAX_MS 500
`define TAP_MAX_TICKS (`TAP_MAX_MS / `TICK_MS)
`define HOLD_MIN_TICKS 7'h19
`define HOLD_MAX_TICKS 9'h1f4
`define HOLD_DEF_TICKS 9'h0c8
`define HOLD_STEP_TICKS 9'h19
`define USER_MIN 6'h0a
`define USER_MAX 6'h32
`define USER_DEF 6'h14
`define LOW_MAX_DEF 12'h00f
`define MID_MAX_DEF 12'h064
`define HIGH_MAX_DEF 12'h5dc
`define SCALE_STEP_LOW 12'h005
`define SCALE_STEP_MID 12'h019
`define SCALE_STEP_HIGH 12'h0fa
`define THR_0W 16'h0000
`define THR_0W1 16'h0001
`define THR_1W 16'h000a
`define THR_10W 16'h0064
`endif

// ===== rtl/meter_pkg.sv
// types for the meter front-panel control block
package meter_pkg;
  typedef enum logic [1:0] {
    PWR_AVG = 2'b00,
    PWR_PEAK = 2'b01,
    PWR_TUNE = 2'b10
  } pwr_mode_t;
  typedef enum logic [2:0] {
    SCR_MAIN = 3'b000,
    SCR_REF = 3'b001,
    SCR_USER = 3'b010,
    SCR_THRESH = 3'b011,
    SCR_RANGE = 3'b100,
    SCR_HOLD = 3'b101,
    SCR_CAL = 3'b110
  } screen_t;
  typedef enum logic [1:0] {
    RNG_LOW = 2'b00,
    RNG_MID = 2'b01,
    RNG_HIGH = 2'b10
  } range_t;
endpackage : meter_pkg

// ===== rtl/meter_setup_menu_control.sv
// front-panel control: power mode, peak hold, alarm snooze, setup menu and settings
`timescale 1ns/1ps
`include "meter_params.svh"
// Functional notes
// R1: peak mode holds peak, higher peak restarts
// R2: up tap advances mode; peak shows capital W
// R3: sample strobe about 100 per second
// R4: alarm tap snoozes alarm for one minute
// R5: mode held one second enters reference screen
// R6: mode held two seconds exits via calibration
// R7: reference: down resets cpu, up toggles units
// R8: user setpoint 1.0 to 5.0, step 0.1
// R9: down cycles threshold 0, 0.1, 1, 10 W
// R10: threshold gates alarm only, not reading
// R11: up toggles forward/net power, net default
// R12: range screen down cycles low/mid/high
// R13: default maxima 15, 100, 1500 W
// R14: operator should set alarm near 2.0
// R15: sounder only when jumper fitted
// R16: repeat tap restarts snooze minute
// R17: hold time 0.25 to 5 s, default 2
// R18: timers on common tick, cleared at reset
module meter_setup_menu_control
  import meter_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // front-panel buttons and sounder jumper (raw pins)
  input wire logic mode_button_i,
  input wire logic up_button_i,
  input wire logic down_button_i,
  input wire logic alarm_sounder_jumper_i,
  // measured data, same clock
  input wire logic [15:0] fwd_pwr_i,
  input wire logic [15:0] ref_pwr_i,
  input wire logic [5:0] swr_i,
  input wire logic [5:0] swr_limit_i,
  // display and outputs
  output logic sample_o,
  output pwr_mode_t pwr_mode_o,
  output logic peak_char_o,
  output logic [15:0] disp_pwr_o,
  output logic [5:0] disp_swr_o,
  output screen_t screen_o,
  output logic temp_celsius_o,
  output logic cpu_reset_o,
  output logic [5:0] user_setpoint_o,
  output logic [15:0] alarm_power_threshold_o,
  output logic net_power_o,
  output range_t range_sel_o,
  output logic [11:0] low_max_o,
  output logic [11:0] mid_max_o,
  output logic [11:0] high_max_o,
  output logic [8:0] hold_ticks_o,
  output logic alarm_o,
  output logic snooze_o,
  output logic sounder_o
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [19:0] div;
    logic tick;
    logic js1;
    logic js2;
    pwr_mode_t pmode;
    screen_t scr;
    logic celsius;
    logic cpu_rst;
    logic [5:0] user;
    logic [1:0] thr_idx;
    logic net;
    range_t rng;
    logic [11:0] lmax;
    logic [11:0] mmax;
    logic [11:0] hmax;
    logic [8:0] hold;
    logic [8:0] hcnt;
    logic [15:0] pk_pwr;
    logic [5:0] pk_swr;
    logic [15:0] dpwr;
    logic [5:0] dswr;
    logic [12:0] snz;
    logic alarm;
  } state_t;
  state_t q, d;
  logic m_tap, m_hold1, m_hold2, u_tap, u_hold, down_tap, a_tap;
  logic [15:0] pwr_now;

  // threshold index to power in tenths of a watt
  function automatic logic [15:0] thr_watts(input logic [1:0] idx);
    unique case (idx)
      2'b00: thr_watts = `THR_0W;
      2'b01: thr_watts = `THR_0W1;
      2'b10: thr_watts = `THR_1W;
      default: thr_watts = `THR_10W;
    endcase
  endfunction : thr_watts

  ////////////////////////////////////////////////////////////////////////////
  // buttons; mode button has two hold thresholds so one long press can go far
  button_timer #(.HOLD_TICKS(`SETUP_HOLD_TICKS)) u_mode1 (.clk_i(clk_i), .resetn_i(resetn_i),
    .tick_i(q.tick), .btn_i(mode_button_i), .tap_o(m_tap), .hold_o(m_hold1));
  button_timer #(.HOLD_TICKS(`EXIT_HOLD_TICKS)) u_mode2 (.clk_i(clk_i), .resetn_i(resetn_i),
    .tick_i(q.tick), .btn_i(mode_button_i), .tap_o(), .hold_o(m_hold2));
  button_timer #(.HOLD_TICKS(`TAP_MAX_TICKS)) u_up (.clk_i(clk_i), .resetn_i(resetn_i),
    .tick_i(q.tick), .btn_i(up_button_i), .tap_o(u_tap), .hold_o(u_hold));
  button_timer #(.HOLD_TICKS(`TAP_MAX_TICKS)) u_down (.clk_i(clk_i), .resetn_i(resetn_i),
    .tick_i(q.tick), .btn_i(down_button_i), .tap_o(down_tap), .hold_o());
  // the alarm button doubles as down; only taps on the main screen snooze, a long press does nothing here
  assign a_tap = down_tap;

  // net is forward minus reflected, floored at zero
  assign pwr_now = !q.net ? fwd_pwr_i : (fwd_pwr_i > ref_pwr_i ? fwd_pwr_i - ref_pwr_i : 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.js1 = alarm_sounder_jumper_i;
    d.js2 = q.js1;
    d.cpu_rst = 1'b0;
    // common tick, also the display sample strobe
    d.tick = 1'b0;
    if (q.div >= 20'(TICK_CYCLES - 1)) begin
      d.div = 20'h00000;
      d.tick = 1'b1; // R3 R18
    end else begin
      d.div = q.div + 20'h00001;
    end
    // menu navigation: the first and the second held second of one mode press each take one step, main to setup to
    // calibration to main, so a two-second hold in setup passes calibration and lands on main
    if (q.scr == SCR_MAIN && (m_hold1 || m_hold2)) begin
      d.scr = SCR_REF; // R5
    end else if (q.scr == SCR_CAL && (m_hold1 || m_hold2)) begin
      d.scr = SCR_MAIN; // R6
    end else if (m_hold1 || m_hold2) begin
      d.scr = SCR_CAL; // R6
    end else if (m_tap && q.scr != SCR_MAIN && q.scr != SCR_CAL) begin
      d.scr = (q.scr == SCR_HOLD) ? SCR_REF : screen_t'(q.scr + 3'b001);
    end
    unique case (q.scr)
      SCR_MAIN: begin
        if (u_tap) begin
          d.pmode = (q.pmode == PWR_TUNE) ? PWR_AVG : pwr_mode_t'(q.pmode + 2'b01); // R2
        end
        if (a_tap) begin
          d.snz = 13'(`SNOOZE_TICKS); // R4 R16
        end
      end
      SCR_REF: begin
        if (down_tap) d.cpu_rst = 1'b1; // R7
        if (u_tap) d.celsius = !q.celsius; // R7
      end
      SCR_USER: begin
        if (down_tap && q.user > `USER_MIN) d.user = q.user - 6'h01; // R8
        if (u_tap && q.user < `USER_MAX) d.user = q.user + 6'h01; // R8
      end
      SCR_THRESH: begin
        if (down_tap) d.thr_idx = q.thr_idx + 2'b01; // R9
        if (u_tap) d.net = !q.net; // R11
      end
      SCR_RANGE: begin
        if (down_tap) d.rng = (q.rng == RNG_HIGH) ? RNG_LOW : range_t'(q.rng + 2'b01); // R12
        if (u_tap) begin
          unique case (q.rng)
            RNG_LOW: d.lmax = q.lmax + `SCALE_STEP_LOW;
            RNG_MID: d.mmax = q.mmax + `SCALE_STEP_MID;
            default: d.hmax = q.hmax + `SCALE_STEP_HIGH;
          endcase
        end
        if (u_hold) begin
          unique case (q.rng)
            RNG_LOW: d.lmax = `SCALE_STEP_LOW;
            RNG_MID: d.mmax = `SCALE_STEP_MID * 12'h002;
            default: d.hmax = `SCALE_STEP_HIGH * 12'h002;
          endcase
        end
      end
      SCR_HOLD: begin
        if (down_tap && q.hold > 9'(`HOLD_MIN_TICKS)) d.hold = q.hold - `HOLD_STEP_TICKS; // R17
        if (u_tap && q.hold < `HOLD_MAX_TICKS) d.hold = q.hold + `HOLD_STEP_TICKS; // R17
      end
      SCR_CAL: begin
      end
      default: d.scr = SCR_MAIN;
    endcase
    // snooze countdown on the tick; a fresh tap wins over the decrement
    if (q.tick && q.snz != 13'h0000 && !(q.scr == SCR_MAIN && a_tap)) d.snz = q.snz - 13'h0001; // R4
    // display sampling with peak hold
    if (q.tick) begin
      if (q.pmode == PWR_AVG) begin
        d.dpwr = pwr_now;
        d.dswr = swr_i;
      end else if (pwr_now > q.pk_pwr || q.hcnt == 9'h000) begin
        d.pk_pwr = pwr_now;
        d.pk_swr = swr_i;
        d.dpwr = pwr_now;
        d.dswr = swr_i;
        d.hcnt = (q.pmode == PWR_TUNE) ? 9'(`HOLD_MIN_TICKS) : q.hold; // R1
      end else begin
        d.hcnt = q.hcnt - 9'h001; // R1
      end
    end
    // threshold gates only the alarm; the shown swr is untouched
    d.alarm = (q.snz == 13'h0000) && (swr_i >= swr_limit_i) && (swr_limit_i != 6'h00)
      && (pwr_now >= thr_watts(q.thr_idx)); // R10
  end

  // state register with factory defaults
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      q <= '0; // R18
      q.net <= 1'b1; // R11
      q.user <= `USER_DEF;
      q.lmax <= `LOW_MAX_DEF; // R13
      q.mmax <= `MID_MAX_DEF; // R13
      q.hmax <= `HIGH_MAX_DEF; // R13
      q.hold <= `HOLD_DEF_TICKS; // R17
      q.pmode <= PWR_AVG;
      q.scr <= SCR_MAIN;
      q.rng <= RNG_LOW;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sample_o = q.tick;
  assign pwr_mode_o = q.pmode;
  assign peak_char_o = (q.pmode == PWR_PEAK); // R2
  assign disp_pwr_o = q.dpwr;
  assign disp_swr_o = q.dswr; // R10
  assign screen_o = q.scr;
  assign temp_celsius_o = q.celsius;
  assign cpu_reset_o = q.cpu_rst;
  assign user_setpoint_o = q.user;
  assign alarm_power_threshold_o = thr_watts(q.thr_idx);
  assign net_power_o = q.net;
  assign range_sel_o = q.rng;
  assign low_max_o = q.lmax;
  assign mid_max_o = q.mmax;
  assign high_max_o = q.hmax;
  assign hold_ticks_o = q.hold;
  assign alarm_o = q.alarm;
  assign snooze_o = (q.snz != 13'h0000);
  assign sounder_o = q.alarm && q.js2; // R15

  ////////////////////////////////////////////////////////////////////////////
  chk_sounder_needs_jumper: assert property (@(posedge clk_i) disable iff (!resetn_i) // R15
    sounder_o |-> q.js2) else $error("sounder without jumper");
  chk_snooze_quiets_alarm: assert property (@(posedge clk_i) disable iff (!resetn_i) // R4
    (q.scr == SCR_MAIN && a_tap) |=> ##1 !alarm_o) else $error("alarm during snooze");
  chk_snooze_restart: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
    (q.scr == SCR_MAIN && a_tap) |=> q.snz == 13'(`SNOOZE_TICKS)) else $error("snooze not restarted");
  chk_user_bounds: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
    user_setpoint_o >= `USER_MIN && user_setpoint_o <= `USER_MAX) else $error("setpoint out of range");
  chk_hold_bounds: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
    hold_ticks_o >= 9'(`HOLD_MIN_TICKS) && hold_ticks_o <= `HOLD_MAX_TICKS) else $error("hold out of range");
  chk_mode_advance: assert property (@(posedge clk_i) disable iff (!resetn_i) // R2
    (q.scr == SCR_MAIN && u_tap && q.pmode == PWR_AVG) |=> pwr_mode_o == PWR_PEAK) else $error("mode no advance");
  chk_ref_cpu_reset: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
    (q.scr == SCR_REF && down_tap) |=> cpu_reset_o) else $error("no cpu reset");
  chk_setup_entry: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
    (q.scr == SCR_MAIN && m_hold1) |=> screen_o == SCR_REF) else $error("setup not entered");
  chk_setup_to_cal: assert property (@(posedge clk_i) disable iff (!resetn_i) // R6
    (q.scr != SCR_MAIN && q.scr != SCR_CAL && (m_hold1 || m_hold2)) |=> screen_o == SCR_CAL)
    else $error("no step to calibration");
  chk_exit_via_cal: assert property (@(posedge clk_i) disable iff (!resetn_i) // R6
    (q.scr == SCR_CAL && m_hold1 && !m_hold2) |=> screen_o == SCR_MAIN) else $error("no exit");
  chk_tick_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i) // R3
    q.tick |=> !q.tick) else $error("tick too dense");
  chk_peak_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // R1
    (q.tick && q.pmode == PWR_PEAK && pwr_now > q.pk_pwr) |=> q.hcnt == q.hold) else $error("hold not restarted");
  cov_snooze: cover property (@(posedge clk_i) snooze_o);
  cov_setup: cover property (@(posedge clk_i) screen_o == SCR_HOLD);
  cov_peak: cover property (@(posedge clk_i) pwr_mode_o == PWR_TUNE);
  cov_sound: cover property (@(posedge clk_i) sounder_o);
endmodule : meter_setup_menu_control
